// ==== rtl/drv_params.svh ====
`ifndef DRV_PARAMS_SVH
`define DRV_PARAMS_SVH

// Task-file register indices on the register port
`define DRV_REG_DATA 4'h0
`define DRV_REG_ERR 4'h1
`define DRV_REG_CNT 4'h2
`define DRV_REG_LOW 4'h3
`define DRV_REG_MID 4'h4
`define DRV_REG_HIGH 4'h5
`define DRV_REG_DEV 4'h6
`define DRV_REG_CMD 4'h7
`define DRV_REG_CTL 4'h8
`define DRV_REG_IST 4'h9
`define DRV_REG_IMSK 4'hA

// Opcodes; verify compares the upper seven bits only
`define DRV_OP_READ_EXT 8'h24
`define DRV_OP_VFY_HI 7'h20

// Error flag positions
`define DRV_ERR_UNC 6
`define DRV_ERR_IDN 4
`define DRV_ERR_ABT 2

// Field positions in device and control registers
`define DRV_DEV_LBA 6
`define DRV_CTL_HOB 7

// Zero-count meanings
`define DRV_EXT_MAX 17'h10000
`define DRV_VFY_MAX 17'h00100

// Reset values
`define DRV_RST_BYTE 8'h00
`define DRV_RST_ADDR 48'h000000000000
`define DRV_RST_CNT 17'h00000

`endif

// ==== rtl/drv_pkg.sv ====
package drv_pkg;
    // Command sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_MEDIA,
        ST_DRAIN
    } drv_state_e;

    // Request towards the media read channel
    typedef struct packed {
        logic start;
        logic lba_mode;
        logic [47:0] addr;
    } drv_media_req_s;

    // Answer from the media read channel
    typedef struct packed {
        logic word_valid;
        logic [15:0] word;
        logic sector_end;
        logic uncorrectable_flag;
        logic idnf;
    } drv_media_in_s;
endpackage

// ==== rtl/drv_cmd_top.sv ====
`include "drv_params.svh"

// How it works
// - 24h reads 1..65536 sectors to host
// - Sector data leaves in 16-bit words
// - Read stops at failing sector on error
// - Extended count is previous:current bytes
// - Extended count zero means 65536 sectors
// - 48-bit address layout, error address via HIGH_ORDER_BYTE_SELECT
// - 40h/41h verifies without host data
// - Verify uses same media access as read
// - Verify count zero means 256 sectors
// - Verify stops at failing sector
// - CHS start when address mode clear
// - LBA28 start from low, mid, high, head
// - Retry bit of opcode ignored
// - Verify leaves unverified count in count
// - Verify reports last processed address
// - LBA low returns bits 0-7
// - Eight-bit count zero means 256
module drv_cmd_top #(
    parameter int SECT_PER_TRK = 63, // CHS geometry
    parameter int HEADS = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_ff,
    // Media read channel
    output drv_pkg::drv_media_req_s media_req_ff,
    output logic media_ready_ff,
    input wire drv_pkg::drv_media_in_s media_in,
    // Interrupt
    output logic irq_ff
);
    drv_pkg::drv_state_e state_ff; // Sequencer state
    drv_pkg::drv_state_e nxt_state;
    logic is_vfy_ff; // Running command is a verify
    logic lba_mode_ff; // Address mode of running command
    logic [47:0] addr_ff; // Address of current sector
    logic [16:0] rem_ff; // Sectors still to process
    logic [7:0] cnt_cur_ff, cnt_prev_ff; // Count bytes
    logic [23:0] lba_cur_ff, lba_prev_ff; // High, mid, low bytes
    logic [7:0] dev_ff; // Device register
    logic hob_ff; // High-order byte select
    logic [7:0] err_ff; // Error flags
    logic [15:0] word_ff; // Held data word
    logic word_held_ff; // A word waits for the host
    logic nxt_word_held;
    logic [2:0] ist_ff, msk_ff; // Done, error, data-ready
    logic [7:0] stat; // Status byte
    logic cmd_wr, go_read, go_vfy, go_abort;
    logic take, pop, sec_end, sec_bad, sec_last, done_evt;
    logic [15:0] ext_cnt;
    logic [47:0] lba28, chs, start_addr;

    // Command decode; writes only land while idle
    assign cmd_wr = reg_wr && reg_addr == `DRV_REG_CMD
        && state_ff == drv_pkg::ST_IDLE;
    assign go_read = cmd_wr && reg_wdata[7:0] == `DRV_OP_READ_EXT;
    assign go_vfy = cmd_wr && reg_wdata[7:1] == `DRV_OP_VFY_HI;
    assign go_abort = cmd_wr && !go_read && !go_vfy;
    assign ext_cnt = {cnt_prev_ff, cnt_cur_ff};
    assign lba28 = {20'h00000, dev_ff[3:0], lba_cur_ff};
    // CHS packs cylinder, head and sector into the low bits
    assign chs = {20'h00000, lba_cur_ff[23:8], dev_ff[3:0],
        lba_cur_ff[7:0]};
    assign start_addr = dev_ff[`DRV_DEV_LBA] ? lba28 : chs;

    // Media handshake terms
    assign take = state_ff == drv_pkg::ST_MEDIA && media_in.word_valid
        && media_ready_ff;
    assign pop = reg_rd && reg_addr == `DRV_REG_DATA && word_held_ff;
    assign sec_end = state_ff == drv_pkg::ST_MEDIA && media_in.sector_end;
    assign sec_bad = sec_end && (media_in.uncorrectable_flag || media_in.idnf);
    assign sec_last = sec_end && !sec_bad && rem_ff == 17'h00001;
    assign done_evt = go_abort || sec_bad || (sec_last && is_vfy_ff)
        || (state_ff == drv_pkg::ST_DRAIN && !word_held_ff);

    // Status byte: ready and seek-done always set
    always_comb begin
        stat = 8'h50;
        stat[7] = state_ff != drv_pkg::ST_IDLE;
        stat[3] = word_held_ff;
        stat[0] = |err_ff;
    end

    // Next-state logic of the sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            drv_pkg::ST_IDLE: begin
                if (go_read || go_vfy) begin
                    nxt_state = drv_pkg::ST_ISSUE;
                end
            end
            drv_pkg::ST_ISSUE: begin
                nxt_state = drv_pkg::ST_MEDIA;
            end
            drv_pkg::ST_MEDIA: begin
                if (sec_bad) begin
                    nxt_state = drv_pkg::ST_IDLE;
                end else if (sec_last) begin
                    nxt_state = is_vfy_ff ? drv_pkg::ST_IDLE
                        : drv_pkg::ST_DRAIN;
                end else if (sec_end) begin
                    nxt_state = drv_pkg::ST_ISSUE;
                end
            end
            drv_pkg::ST_DRAIN: begin
                if (!word_held_ff) begin
                    nxt_state = drv_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = drv_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= drv_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Command latch: kind, address mode, address and count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            is_vfy_ff <= 1'b0;
            lba_mode_ff <= 1'b0;
            addr_ff <= `DRV_RST_ADDR;
            rem_ff <= `DRV_RST_CNT;
        end else if (go_read) begin
            is_vfy_ff <= 1'b0;
            lba_mode_ff <= 1'b1;
            addr_ff <= {lba_prev_ff, lba_cur_ff};
            rem_ff <= ext_cnt == 16'h0000 ? `DRV_EXT_MAX
                : {1'b0, ext_cnt};
        end else if (go_vfy) begin
            is_vfy_ff <= 1'b1;
            lba_mode_ff <= dev_ff[`DRV_DEV_LBA];
            addr_ff <= start_addr;
            rem_ff <= cnt_cur_ff == 8'h00 ? `DRV_VFY_MAX
                : {9'h000, cnt_cur_ff};
        end else if (sec_end && !sec_bad && !sec_last) begin
            // Last good sector keeps its address for reporting
            rem_ff <= rem_ff - 17'h00001;
            if (lba_mode_ff) begin
                addr_ff <= addr_ff + 48'h000000000001;
            end else if (addr_ff[7:0] != 8'(SECT_PER_TRK)) begin
                addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
            end else begin
                addr_ff[7:0] <= 8'h01;
                if (addr_ff[11:8] != 4'(HEADS - 1)) begin
                    addr_ff[11:8] <= addr_ff[11:8] + 4'h1;
                end else begin
                    addr_ff[11:8] <= 4'h0;
                    addr_ff[27:12] <= addr_ff[27:12] + 16'h0001;
                end
            end
        end else if (sec_last) begin
            rem_ff <= `DRV_RST_CNT;
        end
    end

    // Media request: one start pulse per sector, same path for both
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            media_req_ff <= '0;
        end else begin
            media_req_ff.start <= state_ff == drv_pkg::ST_ISSUE;
            media_req_ff.lba_mode <= lba_mode_ff;
            media_req_ff.addr <= addr_ff;
        end
    end

    // One-word holding stage; verify words are dropped
    always_comb begin
        nxt_word_held = word_held_ff;
        if (pop) begin
            nxt_word_held = 1'b0;
        end
        if (take && !is_vfy_ff) begin
            nxt_word_held = 1'b1;
        end
        // A failed sector's pending word is dropped, so no stale TRANSFER_REQUEST_FLAG
        if (sec_bad) begin
            nxt_word_held = 1'b0;
        end
    end

    // Held word and its flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_held_ff <= 1'b0;
            word_ff <= 16'h0000;
        end else begin
            word_held_ff <= nxt_word_held;
            if (take && !is_vfy_ff) begin
                word_ff <= media_in.word;
            end
        end
    end

    // Ready is registered from the next hold state so it never overfills
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            media_ready_ff <= 1'b0;
        end else begin
            media_ready_ff <= (nxt_state == drv_pkg::ST_ISSUE
                || nxt_state == drv_pkg::ST_MEDIA)
                && (is_vfy_ff || go_vfy || !nxt_word_held);
        end
    end

    // Error flags: cleared by a new command, set by the outcome
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_ff <= `DRV_RST_BYTE;
        end else if (cmd_wr) begin
            err_ff <= `DRV_RST_BYTE;
            err_ff[`DRV_ERR_ABT] <= go_abort;
        end else if (sec_bad) begin
            err_ff[`DRV_ERR_UNC] <= media_in.uncorrectable_flag;
            err_ff[`DRV_ERR_IDN] <= media_in.idnf;
        end
    end

    // Task-file bytes: host count and address writes shift current into previous
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_cur_ff <= `DRV_RST_BYTE;
            cnt_prev_ff <= `DRV_RST_BYTE;
            lba_cur_ff <= 24'h000000;
            lba_prev_ff <= 24'h000000;
            dev_ff <= `DRV_RST_BYTE;
        end else if (sec_bad && !is_vfy_ff) begin
            lba_cur_ff <= addr_ff[23:0];
            lba_prev_ff <= addr_ff[47:24];
        end else if (done_evt && is_vfy_ff && !go_abort) begin
            // Failing or final sector, in the command's mode
            cnt_cur_ff <= sec_bad ? rem_ff[7:0] : 8'h00;
            if (lba_mode_ff) begin
                lba_cur_ff <= addr_ff[23:0];
                dev_ff[3:0] <= addr_ff[27:24];
            end else begin
                lba_cur_ff <= {addr_ff[27:12], addr_ff[7:0]};
                dev_ff[3:0] <= addr_ff[11:8];
            end
        end else if (reg_wr && state_ff == drv_pkg::ST_IDLE) begin
            case (reg_addr)
                `DRV_REG_CNT: begin
                    cnt_prev_ff <= cnt_cur_ff;
                    cnt_cur_ff <= reg_wdata[7:0];
                end
                `DRV_REG_LOW: begin
                    lba_prev_ff[7:0] <= lba_cur_ff[7:0];
                    lba_cur_ff[7:0] <= reg_wdata[7:0];
                end
                `DRV_REG_MID: begin
                    lba_prev_ff[15:8] <= lba_cur_ff[15:8];
                    lba_cur_ff[15:8] <= reg_wdata[7:0];
                end
                `DRV_REG_HIGH: begin
                    lba_prev_ff[23:16] <= lba_cur_ff[23:16];
                    lba_cur_ff[23:16] <= reg_wdata[7:0];
                end
                `DRV_REG_DEV: begin
                    dev_ff <= reg_wdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // High-order byte select, writable at any time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hob_ff <= 1'b0;
        end else if (reg_wr && reg_addr == `DRV_REG_CTL) begin
            hob_ff <= reg_wdata[`DRV_CTL_HOB];
        end
    end

    // Sticky events; a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ist_ff <= 3'h0;
            msk_ff <= 3'h0;
        end else begin
            ist_ff <= (ist_ff & ~((reg_wr && reg_addr == `DRV_REG_IST)
                ? reg_wdata[2:0] : 3'h0))
                | {take && !is_vfy_ff, done_evt && (sec_bad || go_abort),
                done_evt};
            if (reg_wr && reg_addr == `DRV_REG_IMSK) begin
                msk_ff <= reg_wdata[2:0];
            end
        end
    end

    // Level interrupt
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(ist_ff & msk_ff);
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata_ff <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `DRV_REG_DATA: reg_rdata_ff <= word_ff;
                `DRV_REG_ERR: reg_rdata_ff <= {8'h00, err_ff};
                `DRV_REG_CNT: reg_rdata_ff <= {8'h00,
                    hob_ff ? cnt_prev_ff : cnt_cur_ff};
                `DRV_REG_LOW: reg_rdata_ff <= {8'h00,
                    hob_ff ? lba_prev_ff[7:0] : lba_cur_ff[7:0]};
                `DRV_REG_MID: reg_rdata_ff <= {8'h00,
                    hob_ff ? lba_prev_ff[15:8] : lba_cur_ff[15:8]};
                `DRV_REG_HIGH: reg_rdata_ff <= {8'h00,
                    hob_ff ? lba_prev_ff[23:16] : lba_cur_ff[23:16]};
                `DRV_REG_DEV: reg_rdata_ff <= {8'h00, dev_ff};
                `DRV_REG_CMD: reg_rdata_ff <= {8'h00, stat};
                `DRV_REG_CTL: reg_rdata_ff <= {8'h00, hob_ff, 7'h00};
                `DRV_REG_IST: reg_rdata_ff <= {13'h0000, ist_ff};
                `DRV_REG_IMSK: reg_rdata_ff <= {13'h0000, msk_ff};
                default: reg_rdata_ff <= 16'h0000;
            endcase
        end else begin
            reg_rdata_ff <= 16'h0000;
        end
    end

    // Checks
    sequence s_issue;
        state_ff == drv_pkg::ST_ISSUE ##1 media_req_ff.start;
    endsequence

    a_ext_count_form: assert property (@(posedge clk) disable iff (!rst_n)
        go_read |=> rem_ff == (($past(ext_cnt) == 16'h0000) ? `DRV_EXT_MAX
        : {1'b0, $past(ext_cnt)})) else $error("ext count wrong");
    a_vfy_count_max: assert property (@(posedge clk) disable iff (!rst_n)
        go_vfy && cnt_cur_ff == 8'h00 |=> rem_ff == `DRV_VFY_MAX)
        else $error("verify zero count wrong");
    a_retry_bit_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_wr && reg_wdata[7:0] == 8'h41 |=> is_vfy_ff ##0 s_issue)
        else $error("41h not verify");
    a_stop_on_error: assert property (@(posedge clk) disable iff (!rst_n)
        sec_bad |=> state_ff == drv_pkg::ST_IDLE ##1 (!media_req_ff.start)[*3])
        else $error("run past bad sector");
    a_no_host_data: assert property (@(posedge clk) disable iff (!rst_n)
        is_vfy_ff && state_ff != drv_pkg::ST_IDLE |-> !word_held_ff)
        else $error("verify moved data");
    a_err_summary: assert property (@(posedge clk) disable iff (!rst_n)
        (err_ff[`DRV_ERR_UNC] || err_ff[`DRV_ERR_IDN] || err_ff[`DRV_ERR_ABT])
        |-> stat[0]) else $error("summary error missing");
    a_vfy_done_count: assert property (@(posedge clk) disable iff (!rst_n)
        sec_last && is_vfy_ff |=> cnt_cur_ff == 8'h00
        && lba_cur_ff[7:0] == $past(addr_ff[7:0]))
        else $error("verify result wrong");
    a_ext_err_addr: assert property (@(posedge clk) disable iff (!rst_n)
        sec_bad && !is_vfy_ff |=> {lba_prev_ff, lba_cur_ff} == $past(addr_ff))
        else $error("error address wrong");
    a_lba28_start: assert property (@(posedge clk) disable iff (!rst_n)
        go_vfy && dev_ff[`DRV_DEV_LBA] |=> addr_ff == $past(lba28) ##1
        media_req_ff.addr == $past(lba28, 2))
        else $error("lba28 wrong");
    a_word_pop: assert property (@(posedge clk) disable iff (!rst_n)
        pop && !take |=> reg_rdata_ff == $past(word_ff) && !word_held_ff)
        else $error("data word not delivered");
endmodule // drv_cmd_top

// ==== verification/drv_media_model.sv ====
// Far side of the media channel: serves WORDS words per started sector
module drv_media_model #(
    parameter int WORDS = 4 // Words per sector, kept short for run time
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Device side
    input wire drv_pkg::drv_media_req_s req,
    input wire logic ready,
    output drv_pkg::drv_media_in_s media_in,
    // Bench control
    input wire logic slow,
    input wire logic [15:0] fail_at
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_ff; // A sector is being served
    logic [3:0] widx_ff; // Word index within the sector
    logic [47:0] adr_ff; // Address of the sector in service
    logic tick_ff; // Lets a new word be offered only in alternate cycles when slow

    // Word offer, hand-over and sector close
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            media_in <= '0;
            busy_ff <= 1'b0;
            widx_ff <= 4'h0;
            adr_ff <= 48'h000000000000;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= ~tick_ff;
            media_in.sector_end <= 1'b0;
            media_in.uncorrectable_flag <= 1'b0;
            media_in.idnf <= 1'b0;
            if (req.start) begin
                busy_ff <= 1'b1;
                widx_ff <= 4'h0;
                adr_ff <= req.addr;
                media_in.word_valid <= 1'b0;
            end else if (media_in.word_valid && ready) begin
                // Taken: the held word is released and the line flips
                media_in.word_valid <= 1'b0;
                media_in.word <= ~media_in.word;
                widx_ff <= widx_ff + 4'h1;
                if (widx_ff == 4'(WORDS - 1)) begin
                    busy_ff <= 1'b0;
                    media_in.sector_end <= 1'b1;
                    media_in.uncorrectable_flag <= (adr_ff[15:0] == fail_at);
                end
            end else if (!media_in.word_valid) begin
                // Offer next word; idle data toggles so it is never stale
                media_in.word_valid <= busy_ff && (!slow || tick_ff);
                media_in.word <= busy_ff ? {adr_ff[11:0], widx_ff}
                                         : ~media_in.word;
            end
        end
    end
endmodule // drv_media_model

// ==== verification/disk_read_verify_cmd_bench.sv ====
`include "drv_params.svh"

module disk_read_verify_cmd_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WORDS = 4; // Words per sector served by the model
    // Design connections
    logic clk;
    logic rst_n;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata_ff;
    drv_pkg::drv_media_req_s media_req_ff;
    logic media_ready_ff;
    drv_pkg::drv_media_in_s media_in;
    logic irq_ff;
    // Model control and reference state
    logic slow;
    logic exp_lba;
    logic [15:0] fail_at;
    logic [15:0] rnd;
    logic [15:0] rdata;
    logic [47:0] base;
    logic [47:0] t;
    int n_fail;
    int compares;
    int n_start;
    int nw;
    int i;
    int n;

    drv_cmd_top i_drv_cmd_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .media_req_ff(media_req_ff),
        .media_ready_ff(media_ready_ff), .media_in(media_in),
        .irq_ff(irq_ff));

    drv_media_model #(.WORDS(WORDS)) i_drv_media_model (.clk(clk),
        .rst_n(rst_n), .req(media_req_ff), .ready(media_ready_ff),
        .media_in(media_in), .slow(slow), .fail_at(fail_at));

    // Free-running clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Pseudo-random 16-bit words for addresses
    function logic [15:0] step();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return rnd;
    endfunction

    task chk(input string what, input logic [47:0] seen,
             input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One-cycle register write
    task wb(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= {8'h00, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the following cycle
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rdata = reg_rdata_ff;
    endtask

    // Load task file, previous bytes ahead of current, then issue
    task setup(input logic [15:0] c, input logic [47:0] a,
               input logic [7:0] dev, input logic [7:0] op);
        n_start = 0;
        wb(`DRV_REG_CNT, c[15:8]);
        wb(`DRV_REG_CNT, c[7:0]);
        for (int k = 0; k < 3; k++) begin
            wb(4'(3 + k), a[24 + 8 * k +: 8]);
            wb(4'(3 + k), a[8 * k +: 8]);
        end
        wb(`DRV_REG_DEV, dev);
        wb(`DRV_REG_CMD, op);
    endtask

    // Poll until idle, emptying the data port whenever it is offered
    task drain(input logic xfer);
        nw = 0;
        for (i = 0; i < 20000; i++) begin
            rd(`DRV_REG_CMD);
            if (rdata[7] !== 1'b1) break;
            if (!xfer) chk("data request", 48'(rdata[3]), 48'h0);
            if (rdata[3] === 1'b1) begin
                t = base + 48'(nw / WORDS);
                rd(`DRV_REG_DATA);
                chk("data", 48'(rdata),
                    {32'h0, t[11:0], 4'(nw % WORDS)});
                nw++;
            end
        end
        if (i == 20000) chk("busy", 48'h1, 48'h0);
    endtask

    // Sector starts, error flags and summary status after a command
    task ends(input logic [7:0] err, input int starts);
        chk("starts", 48'(n_start), 48'(starts));
        rd(`DRV_REG_ERR);
        chk("error flags", 48'(rdata), 48'(err));
        rd(`DRV_REG_CMD);
        chk("status", 48'(rdata), 48'(8'h50 | 8'(err != 8'h00)));
    endtask

    // Count left and address of last sector after a verify
    task back(input logic [7:0] cnt, input logic [27:0] a);
        rd(`DRV_REG_CNT);
        chk("count left", 48'(rdata), 48'(cnt));
        for (int k = 0; k < 3; k++) begin
            rd(4'(3 + k));
            chk("last address", 48'(rdata), 48'(a[8 * k +: 8]));
        end
        rd(`DRV_REG_DEV);
        chk("last head", 48'(rdata[3:0]), 48'(a[27:24]));
    endtask

    task irq_is(input logic v);
        repeat (2) @(negedge clk);
        chk("interrupt", 48'(irq_ff), 48'(v));
    endtask

    // Sector addresses requested from the media
    always @(negedge clk) begin
        if (rst_n === 1'b1 && media_req_ff.start === 1'b1) begin
            chk("sector address", media_req_ff.addr,
                base + 48'(n_start));
            chk("address mode", 48'(media_req_ff.lba_mode),
                48'(exp_lba));
            n_start++;
        end
    end

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        test_done;
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        slow = 1'b0;
        exp_lba = 1'b1;
        fail_at = 16'h0000;
        rnd = 16'h6229;
        base = 48'h0;
        n_fail = 0;
        compares = 0;
        n_start = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // Idle state and an unmapped index
        ends(8'h00, 0);
        wb(4'hB, 8'hFF);
        rd(4'hB);
        chk("unmapped", 48'(rdata), 48'h0);
        wb(`DRV_REG_IMSK, 8'h03);
        // Long extended read, far side stalling
        slow = 1'b1;
        base = {step(), step(), step()};
        fail_at = base[15:0] - 16'h1;
        setup(16'h0102, base, 8'h40, `DRV_OP_READ_EXT);
        drain(1'b1);
        chk("words", 48'(nw), 48'(258 * WORDS));
        ends(8'h00, 258);
        rd(`DRV_REG_IST);
        chk("event flags", 48'(rdata), 48'h5);
        irq_is(1'b1);
        wb(`DRV_REG_IST, 8'h07);
        irq_is(1'b0);
        // Extended read failing in its third sector
        slow = 1'b0;
        base = {step(), step(), step()};
        fail_at = base[15:0] + 16'h2;
        setup(16'h0005, base, 8'h40, `DRV_OP_READ_EXT);
        drain(1'b1);
        ends(8'h40, 3);
        t = base + 48'h2;
        for (int k = 0; k < 6; k++) begin
            if (k == 3) wb(`DRV_REG_CTL, 8'h80);
            rd(4'(3 + k % 3));
            chk("failing address", 48'(rdata), 48'(t[8 * k +: 8]));
        end
        wb(`DRV_REG_CTL, 8'h00);
        // Masking hides the pending error, clearing drops it
        wb(`DRV_REG_IMSK, 8'h00);
        irq_is(1'b0);
        wb(`DRV_REG_IMSK, 8'h03);
        irq_is(1'b1);
        wb(`DRV_REG_IST, 8'h07);
        irq_is(1'b0);
        // Verify: both opcodes, short count and zero count
        for (int v = 0; v < 4; v++) begin
            n = (v < 2) ? 2 : 256;
            base = {20'h00000, 12'h1A0, step()};
            fail_at = base[15:0] - 16'h1;
            setup(16'(n % 256), base, 8'h41, v[0] ? 8'h41 : 8'h40);
            drain(1'b0);
            ends(8'h00, n);
            t = base + 48'(n - 1);
            back(8'h00, t[27:0]);
        end
        // Verify failing in its second of four sectors
        base = {20'h00000, 12'h1A0, step()};
        fail_at = base[15:0] + 16'h1;
        setup(16'h0004, base, 8'h41, 8'h40);
        drain(1'b0);
        ends(8'h40, 2);
        t = base + 48'h1;
        back(8'h03, t[27:0]);
        // Cylinder, head and sector verify of one sector
        exp_lba = 1'b0;
        fail_at = 16'hFFFF;
        base = {20'h00000, 16'h0123, 4'h3, 8'h05};
        setup(16'h0001, {24'h0, 8'h01, 8'h23, 8'h05}, 8'h03, 8'h40);
        drain(1'b0);
        ends(8'h00, 1);
        back(8'h00, 28'h3012305);
        exp_lba = 1'b1;
        // Unknown opcode is refused at once
        n_start = 0;
        wb(`DRV_REG_IST, 8'h07);
        wb(`DRV_REG_CMD, 8'hFF);
        repeat (4) @(negedge clk);
        ends(8'h04, 0);
        rd(`DRV_REG_IST);
        chk("event flags", 48'(rdata), 48'h3);
        test_done;
    end
endmodule // disk_read_verify_cmd_bench
